// [ocrg_top.sv]
`timescale 1ns/1ps
`default_nettype none
module ocrg_top
(
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   input  wire logic [ocrg_pkg::AW-1:0]      s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [ocrg_pkg::DW-1:0]      s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [ocrg_pkg::AW-1:0]      s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [ocrg_pkg::DW-1:0]           s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   input  wire logic                         failsafe_clock_monitor_fail,
   input  wire logic                         idle_mode,
   input  wire logic                         sleep_mode,
   input  wire logic [ocrg_pkg::REF_SRC_N-1:0] ref_src_levels,
   output logic                              irq,
   output logic                              usb_fast_rc_select,
   output logic                              secondary_osc_enable,
   output logic                              osc_switch_busy,
   output logic [2:0]                        current_osc,
   output logic signed [ocrg_pkg::TUNE_W-1:0] fast_rc_tune_code,
   output logic                              ref_clock_out_pin,
   output logic                              ref_request_active
);

   ocrg_pkg::ocrg_state_t s_r;
   ocrg_pkg::ocrg_state_t s_nxt;
   logic                  aw_take;
   logic                  w_take;
   logic                  ar_take;
   logic                  gen_clk;
   logic                  gen_tick;
   logic                  sel_level;
   logic                  ref_run;
   logic                  slp_keep;

   // Read view of every register; unimplemented bits stay zero
   function automatic logic [ocrg_pkg::DW-1:0] reg_view(input ocrg_pkg::ocrg_state_t s,
                                                        input logic [ocrg_pkg::AW-1:0] a);
      logic [ocrg_pkg::DW-1:0] v;
      v = '0;
      case (a)
         ocrg_pkg::OFS_OSC_CTL:
         begin
            v[ocrg_pkg::OSC_FAIL_BIT]  = s.clock_fail;
            v[ocrg_pkg::OSC_USBFR_BIT] = s.usb_fast_rc;
            v[ocrg_pkg::OSC_SOSC_BIT]  = s.sosc_en;
            v[ocrg_pkg::OSC_SWREQ_BIT] = s.osw_req;
            v[ocrg_pkg::OSC_NEW_LSB +: 3] = s.new_osc_selection;
            v[ocrg_pkg::OSC_CUR_LSB +: 3] = s.cosc;
         end
         ocrg_pkg::OFS_TUNE:
            v[ocrg_pkg::TUNE_W-1:0] = s.tune;
         ocrg_pkg::OFS_REF_CTL:
         begin
            v[ocrg_pkg::REF_SEL_LSB +: 4] = s.ref_source_select;
            v[ocrg_pkg::REF_ACT_BIT]  = s.active;
            v[ocrg_pkg::REF_DSW_BIT]  = s.divsw;
            v[ocrg_pkg::REF_REF_RUN_IN_SLEEP_BIT] = s.ref_run_in_sleep;
            v[ocrg_pkg::REF_OE_BIT]   = s.oe;
            v[ocrg_pkg::REF_STOP_IN_IDLE_BIT] = s.stop_in_idle;
            v[ocrg_pkg::REF_ON_BIT]   = s.ref_on;
            v[ocrg_pkg::REF_DIV_LSB +: ocrg_pkg::REF_DIV_W] = s.shadow.div;
         end
         ocrg_pkg::OFS_REF_TRIM:
            v[ocrg_pkg::REF_TRIM_LSB +: ocrg_pkg::REF_TRIM_W] = s.shadow.trim;
         ocrg_pkg::OFS_IRQ_STAT:
            v[ocrg_pkg::IRQ_W-1:0] = s.irq_stat;
         ocrg_pkg::OFS_IRQ_MASK:
            v[ocrg_pkg::IRQ_W-1:0] = s.irq_mask;
         default:
            v = '0;
      endcase
      return v;
   endfunction

   function automatic logic is_mapped(input logic [ocrg_pkg::AW-1:0] a);
      logic m;
      m = (a == ocrg_pkg::OFS_OSC_CTL)  || (a == ocrg_pkg::OFS_TUNE) ||
          (a == ocrg_pkg::OFS_REF_CTL)  || (a == ocrg_pkg::OFS_REF_TRIM) ||
          (a == ocrg_pkg::OFS_UNLOCK)   || (a == ocrg_pkg::OFS_IRQ_STAT) ||
          (a == ocrg_pkg::OFS_IRQ_MASK);
      return m;
   endfunction

   assign s_axi_awready = ~s_r.aw_have & ~s_r.bvalid;
   assign s_axi_wready  = ~s_r.w_have & ~s_r.bvalid;
   assign s_axi_arready = ~s_r.rvalid;
   assign aw_take       = s_axi_awvalid & s_axi_awready;
   assign w_take        = s_axi_wvalid & s_axi_wready;
   assign ar_take       = s_axi_arvalid & s_axi_arready;

   // Reserved source codes select no clock at all
   assign sel_level = (s_r.ref_source_select <= ocrg_pkg::REF_SEL_LAST) ?
                      ref_src_levels[s_r.ref_source_select] : 1'b0;
   // System and bus clocks stop in Sleep, so run-in-sleep cannot apply to them
   assign slp_keep  = s_r.ref_run_in_sleep & (s_r.ref_source_select != ocrg_pkg::REF_SEL_SYS) &
                      (s_r.ref_source_select != ocrg_pkg::REF_SEL_PB);
   assign ref_run   = s_r.ref_on & ~(idle_mode & s_r.stop_in_idle) &
                      ~(sleep_mode & ~slp_keep);

   ocrg_frac_div u_div
   (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .src_level (sel_level),
      .run       (ref_run),
      .cfg       (s_r.act),
      .clk_out   (gen_clk),
      .edge_tick (gen_tick)
   );

   always_comb
   begin
      logic [ocrg_pkg::DW-1:0] d;
      logic [ocrg_pkg::IRQ_W-1:0] ev;
      logic                       start_sw;
      d        = '0;
      ev       = '0;
      start_sw = 1'b0;
      s_nxt    = s_r;

      // Write channel capture, address and data in either order
      if (aw_take)
      begin
         s_nxt.aw_have = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (w_take)
      begin
         s_nxt.w_have = 1'b1;
         s_nxt.w_data = s_axi_wdata;
         s_nxt.w_strb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready)
         s_nxt.bvalid = 1'b0;
      if (s_r.rvalid && s_axi_rready)
         s_nxt.rvalid = 1'b0;

      // Hardware events
      if (failsafe_clock_monitor_fail)
      begin
         ev[ocrg_pkg::IRQ_FAIL_BIT] = 1'b1;
      end
      if (s_r.osw_req)
      begin
         if (s_r.sw_cnt == ocrg_pkg::OSC_SWITCH_LAST)
         begin
            s_nxt.osw_req = 1'b0;
            s_nxt.cosc    = s_r.new_osc_selection;
            s_nxt.sw_cnt  = '0;
            ev[ocrg_pkg::IRQ_OSW_BIT] = 1'b1;
         end
         else
         begin
            s_nxt.sw_cnt = s_r.sw_cnt + 8'h01;
         end
      end
      if (s_r.divsw && gen_tick)
      begin
         s_nxt.divsw = 1'b0;
         ev[ocrg_pkg::IRQ_DSW_BIT] = 1'b1;
      end

      // Register write once both halves are in
      if (s_r.aw_have && s_r.w_have)
      begin
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have  = 1'b0;
         s_nxt.bvalid  = 1'b1;
         s_nxt.bresp   = is_mapped(s_r.aw_addr) ? ocrg_pkg::RESP_OKAY : ocrg_pkg::RESP_SLVERR;
         d = ocrg_pkg::wmerge(reg_view(s_r, s_r.aw_addr), s_r.w_data, s_r.w_strb);
         case (s_r.aw_addr)
            ocrg_pkg::OFS_UNLOCK:
            begin
               // Any stray value relocks; a full write is needed for each key
               s_nxt.key_step = (d == ocrg_pkg::UNLOCK_KEY1);
               s_nxt.unlocked = s_r.key_step && (d == ocrg_pkg::UNLOCK_KEY2);
            end
            ocrg_pkg::OFS_OSC_CTL:
            begin
               if (s_r.unlocked)
               begin
                  s_nxt.usb_fast_rc = d[ocrg_pkg::OSC_USBFR_BIT];
                  s_nxt.sosc_en     = d[ocrg_pkg::OSC_SOSC_BIT];
                  s_nxt.new_osc_selection        = d[ocrg_pkg::OSC_NEW_LSB +: 3];
                  s_nxt.clock_fail  = d[ocrg_pkg::OSC_FAIL_BIT];
                  start_sw          = d[ocrg_pkg::OSC_SWREQ_BIT] & ~s_r.osw_req;
               end
            end
            ocrg_pkg::OFS_TUNE:
            begin
               if (s_r.unlocked)
                  s_nxt.tune = d[ocrg_pkg::TUNE_W-1:0];
            end
            ocrg_pkg::OFS_REF_CTL:
            begin
               s_nxt.ref_on      = d[ocrg_pkg::REF_ON_BIT];
               s_nxt.stop_in_idle        = d[ocrg_pkg::REF_STOP_IN_IDLE_BIT];
               s_nxt.oe          = d[ocrg_pkg::REF_OE_BIT];
               s_nxt.ref_run_in_sleep        = d[ocrg_pkg::REF_REF_RUN_IN_SLEEP_BIT];
               s_nxt.ref_source_select       = d[ocrg_pkg::REF_SEL_LSB +: 4];
               s_nxt.shadow.div  = d[ocrg_pkg::REF_DIV_LSB +: ocrg_pkg::REF_DIV_W];
               if (d[ocrg_pkg::REF_DSW_BIT] && !s_r.divsw)
               begin
                  s_nxt.divsw = 1'b1;
                  s_nxt.act   = s_nxt.shadow;
               end
            end
            ocrg_pkg::OFS_REF_TRIM:
               s_nxt.shadow.trim = d[ocrg_pkg::REF_TRIM_LSB +: ocrg_pkg::REF_TRIM_W];
            ocrg_pkg::OFS_IRQ_MASK:
               s_nxt.irq_mask = d[ocrg_pkg::IRQ_W-1:0];
            default:
               s_nxt.key_step = s_r.key_step;
         endcase
      end

      if (start_sw)
      begin
         s_nxt.osw_req = 1'b1;
         s_nxt.sw_cnt  = '0;
      end

      // Disabled generator takes new divider values straight away
      if (!s_nxt.ref_on)
         s_nxt.act = s_nxt.shadow;

      // Read channel; a status read clears what it returned
      if (ar_take)
      begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata  = reg_view(s_r, s_axi_araddr);
         s_nxt.rresp  = is_mapped(s_axi_araddr) ? ocrg_pkg::RESP_OKAY : ocrg_pkg::RESP_SLVERR;
         if (s_axi_araddr == ocrg_pkg::OFS_IRQ_STAT)
            s_nxt.irq_stat = '0;
      end

      // Sets come last so an event wins over a clear in the same cycle
      if (failsafe_clock_monitor_fail)
         s_nxt.clock_fail = 1'b1;
      s_nxt.irq_stat = s_nxt.irq_stat | ev;

      s_nxt.active = ref_run;
      s_nxt.pin    = gen_clk & s_r.oe & ref_run;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_r      <= '0;
         s_r.new_osc_selection <= ocrg_pkg::OSC_SEL_RESET;
         s_r.cosc <= ocrg_pkg::OSC_SEL_RESET;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_bvalid         = s_r.bvalid;
   assign s_axi_bresp          = s_r.bresp;
   assign s_axi_rvalid         = s_r.rvalid;
   assign s_axi_rresp          = s_r.rresp;
   assign s_axi_rdata          = s_r.rdata;
   assign irq                  = |(s_r.irq_stat & s_r.irq_mask);
   assign usb_fast_rc_select   = s_r.usb_fast_rc;
   assign secondary_osc_enable = s_r.sosc_en;
   assign osc_switch_busy      = s_r.osw_req;
   assign current_osc          = s_r.cosc;
   assign fast_rc_tune_code    = s_r.tune;
   assign ref_clock_out_pin    = s_r.pin;
   assign ref_request_active   = s_r.active;

endmodule // ocrg_top
`default_nettype wire

// [ocrg_pkg.sv]
package ocrg_pkg;

   localparam int unsigned AW = 8;
   localparam int unsigned DW = 32;

   // Register byte addresses
   localparam logic [7:0] OFS_OSC_CTL  = 8'h00;
   localparam logic [7:0] OFS_TUNE     = 8'h10;
   localparam logic [7:0] OFS_REF_CTL  = 8'h20;
   localparam logic [7:0] OFS_REF_TRIM = 8'h30;
   localparam logic [7:0] OFS_UNLOCK   = 8'h40;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h50;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h54;

   // Oscillator control fields
   localparam int unsigned OSC_SWREQ_BIT = 0;
   localparam int unsigned OSC_SOSC_BIT  = 1;
   localparam int unsigned OSC_USBFR_BIT = 2;
   localparam int unsigned OSC_FAIL_BIT  = 3;
   localparam int unsigned OSC_NEW_LSB   = 8;
   localparam int unsigned OSC_CUR_LSB   = 12;
   localparam logic [2:0]  OSC_SEL_RESET = 3'h0;

   // Reference control fields
   localparam int unsigned REF_SEL_LSB   = 0;
   localparam int unsigned REF_ACT_BIT   = 8;
   localparam int unsigned REF_DSW_BIT   = 9;
   localparam int unsigned REF_REF_RUN_IN_SLEEP_BIT  = 11;
   localparam int unsigned REF_OE_BIT    = 12;
   localparam int unsigned REF_STOP_IN_IDLE_BIT  = 13;
   localparam int unsigned REF_ON_BIT    = 15;
   localparam int unsigned REF_DIV_LSB   = 16;
   localparam int unsigned REF_DIV_W     = 15;
   localparam int unsigned REF_TRIM_LSB  = 23;
   localparam int unsigned REF_TRIM_W    = 9;
   localparam int unsigned TUNE_W        = 6;
   localparam logic [3:0]  REF_SEL_SYS   = 4'h0;
   localparam logic [3:0]  REF_SEL_PB    = 4'h1;
   localparam logic [3:0]  REF_SEL_LAST  = 4'h8;
   localparam int unsigned REF_SRC_N     = 9;

   // Interrupt status bits
   localparam int unsigned IRQ_W         = 3;
   localparam int unsigned IRQ_FAIL_BIT  = 0;
   localparam int unsigned IRQ_OSW_BIT   = 1;
   localparam int unsigned IRQ_DSW_BIT   = 2;

   // Unlock keys, arbitrary values
   localparam logic [31:0] UNLOCK_KEY1   = 32'hC3A5_5A3C;
   localparam logic [31:0] UNLOCK_KEY2   = 32'h3C5A_A5C3;

   // Oscillator switch settling time
   localparam int unsigned CLK_PERIOD_PS = 4000;
   localparam int unsigned OSC_SWITCH_NS = 100;
   localparam int unsigned OSC_SWITCH_CYC =
      (OSC_SWITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [7:0]  OSC_SWITCH_LAST = 8'(OSC_SWITCH_CYC - 1);

   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [REF_DIV_W-1:0]  div;
      logic [REF_TRIM_W-1:0] trim;
   } ocrg_ref_cfg_t;

   typedef struct packed {
      logic                  src_q;
      logic [REF_DIV_W:0]    cnt;
      logic [REF_TRIM_W-1:0] acc;
      logic                  extra;
      logic                  out;
      logic                  edge_tick;
   } ocrg_div_state_t;

   typedef struct packed {
      logic                  aw_have;
      logic [AW-1:0]         aw_addr;
      logic                  w_have;
      logic [DW-1:0]         w_data;
      logic [3:0]            w_strb;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  rvalid;
      logic [1:0]            rresp;
      logic [DW-1:0]         rdata;
      logic                  key_step;
      logic                  unlocked;
      logic                  clock_fail;
      logic                  usb_fast_rc;
      logic                  sosc_en;
      logic                  osw_req;
      logic [2:0]            new_osc_selection;
      logic [2:0]            cosc;
      logic [7:0]            sw_cnt;
      logic [TUNE_W-1:0]     tune;
      logic                  ref_on;
      logic                  stop_in_idle;
      logic                  oe;
      logic                  ref_run_in_sleep;
      logic                  divsw;
      logic [3:0]            ref_source_select;
      ocrg_ref_cfg_t         shadow;
      ocrg_ref_cfg_t         act;
      logic                  active;
      logic                  pin;
      logic [IRQ_W-1:0]      irq_stat;
      logic [IRQ_W-1:0]      irq_mask;
   } ocrg_state_t;

   // Byte-lane merge of a write into an old value
   function automatic logic [DW-1:0] wmerge(input logic [DW-1:0] old_v,
                                            input logic [DW-1:0] new_v,
                                            input logic [3:0]    strb);
      logic [DW-1:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            r[i*8 +: 8] = new_v[i*8 +: 8];
      return r;
   endfunction

endpackage

// [ocrg_frac_div.sv]
`timescale 1ns/1ps
`default_nettype none
// Divides a sampled source level by 2*(div + trim/512); div of zero passes it through.
module ocrg_frac_div
(
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   src_level,
   input  wire logic                   run,
   input  wire ocrg_pkg::ocrg_ref_cfg_t cfg,
   output logic                        clk_out,
   output logic                        edge_tick
);

   ocrg_pkg::ocrg_div_state_t s_r;
   ocrg_pkg::ocrg_div_state_t s_nxt;
   logic                      rise;
   logic [ocrg_pkg::REF_DIV_W:0] target;
   logic [ocrg_pkg::REF_TRIM_W:0] sum;

   assign rise   = src_level & ~s_r.src_q;
   assign target = {1'b0, cfg.div} + {{ocrg_pkg::REF_DIV_W{1'b0}}, s_r.extra};
   assign sum    = {1'b0, s_r.acc} + {1'b0, cfg.trim};

   always_comb
   begin
      s_nxt           = s_r;
      s_nxt.src_q     = src_level;
      s_nxt.edge_tick = 1'b0;
      if (!run)
      begin
         // Stopped: values load at once, so a pending switch completes
         s_nxt.cnt       = '0;
         s_nxt.acc       = '0;
         s_nxt.extra     = 1'b0;
         s_nxt.out       = 1'b0;
         s_nxt.edge_tick = 1'b1;
      end
      else if (cfg.div == '0)
      begin
         s_nxt.out       = src_level;
         s_nxt.cnt       = '0;
         s_nxt.edge_tick = rise;
      end
      else if (rise)
      begin
         if (s_r.cnt + 1'b1 >= target)
         begin
            // Each half period lasts div or div+1 edges; the carry spreads the trim
            s_nxt.cnt       = '0;
            s_nxt.out       = ~s_r.out;
            s_nxt.acc       = sum[ocrg_pkg::REF_TRIM_W-1:0];
            s_nxt.extra     = sum[ocrg_pkg::REF_TRIM_W];
            s_nxt.edge_tick = 1'b1;
         end
         else
         begin
            s_nxt.cnt = s_r.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign clk_out   = s_r.out;
   assign edge_tick = s_r.edge_tick;

endmodule // ocrg_frac_div
`default_nettype wire

// [ocrg_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module ocrg_checker
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        usb_fast_rc_select,
   input wire logic        secondary_osc_enable,
   input wire logic        osc_switch_busy,
   input wire logic        ref_clock_out_pin,
   input wire logic        ref_request_active
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_idle2;
      !ref_request_active ##1 !ref_request_active;
   endsequence
   property p_wr_answer; s_wr_both |-> ##2 s_axi_bvalid; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer not in time");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
   property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken while answering");
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer not in time");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data not held");
   // Switch settles over tens of cycles, never instantly nor forever
   property p_sw_busy;
      $rose(osc_switch_busy) |-> osc_switch_busy[*8] ##[1:30] !osc_switch_busy;
   endproperty
   a_sw_busy: assert property (p_sw_busy) else $error("switch busy span wrong");
   property p_usb_cause; $changed(usb_fast_rc_select) |-> $rose(s_axi_bvalid); endproperty
   a_usb_cause: assert property (p_usb_cause) else $error("usb select moved alone");
   property p_sosc_cause; $changed(secondary_osc_enable) |-> $rose(s_axi_bvalid); endproperty
   a_sosc_cause: assert property (p_sosc_cause) else $error("sosc enable moved alone");
   property p_pin_quiet; s_idle2 |-> !ref_clock_out_pin; endproperty
   a_pin_quiet: assert property (p_pin_quiet) else $error("pin toggles while stopped");
endmodule // ocrg_checker
bind ocrg_top ocrg_checker u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .usb_fast_rc_select(usb_fast_rc_select), .secondary_osc_enable(secondary_osc_enable),
   .osc_switch_busy(osc_switch_busy), .ref_clock_out_pin(ref_clock_out_pin),
   .ref_request_active(ref_request_active));
`default_nettype wire

// [osc_control_and_ref_clock_gen_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module osc_control_and_ref_clock_gen_tb;
   logic              aclk = 1'h0, aresetn = 1'h0, pin_q = 1'h0;
   logic [7:0]        awa = 8'h00, ara = 8'h00;
   logic [31:0]       wd = 32'h0, rdata, d;
   logic              awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
   logic              awr, wrdy, bv, arr, rv, irq, usb, sosc, busy, pin, act;
   logic [1:0]        br, rr, r;
   logic [2:0]        cosc;
   logic signed [5:0] tune;
   logic              fail = 1'h0, idle = 1'h0, slp = 1'h0;
   logic [8:0]        src = 9'h000;
   logic [7:0]        regs [4] = '{8'h00, 8'h10, 8'h20, 8'h30};
   int                err_total = 0, compares = 0, n;

   ocrg_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .failsafe_clock_monitor_fail(fail), .idle_mode(idle), .sleep_mode(slp),
      .ref_src_levels(src), .irq(irq), .usb_fast_rc_select(usb),
      .secondary_osc_enable(sosc), .osc_switch_busy(busy), .current_osc(cosc),
      .fast_rc_tune_code(tune), .ref_clock_out_pin(pin), .ref_request_active(act));

   always #2 aclk = ~aclk;
   // Every source toggles each cycle, so a source rising edge comes every 2 cycles
   always @(posedge aclk) src <= ~src;
   always @(negedge aclk) pin_q <= pin;

   task automatic conclude();
      if (err_total == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask

   // Ends on a falling edge so that callers see settled outputs
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic pa, pw;
      pa = 1'h1;
      pw = 1'h1;
      @(posedge aclk);
      awa <= a;
      wd <= v;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      while (pa || pw)
      begin
         @(posedge aclk);
         pa = pa && !awr;
         pw = pw && !wrdy;
         awv <= pa;
         wv <= pw;
      end
      do @(posedge aclk); while (!bv);
      r = br;
      bry <= 1'h0;
      @(negedge aclk);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge aclk);
      ara <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      do @(posedge aclk); while (!arr);
      arv <= 1'h0;
      do @(posedge aclk); while (!rv);
      d = rdata;
      rry <= 1'h0;
      @(negedge aclk);
      chk(nm, e, d);
   endtask

   // Cycles between two rising pin edges; 400 when the pin stays still
   task automatic per();
      int k;
      k = 0;
      n = 0;
      while (k < 2 && n < 400)
      begin
         @(negedge aclk);
         n++;
         k += int'(pin && !pin_q);
         if (k == 1 && pin && !pin_q) n = 0;
      end
   endtask

   initial
   begin
      repeat (20000) @(posedge aclk);
      err_total++;
      conclude();
   end

   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      foreach (regs[i]) rc(regs[i], 32'h0, "reset value");
      wr(8'h10, 32'h15);
      rc(8'h10, 32'h0, "locked tune");
      wr(8'h08, 32'h1);
      chk("unmapped resp", 32'h2, {30'h0, r});
      rc(8'h08, 32'h0, "unmapped read");
      chk("unmapped rresp", 32'h2, {30'h0, rr});
      wr(ocrg_pkg::OFS_UNLOCK, ocrg_pkg::UNLOCK_KEY1);
      wr(ocrg_pkg::OFS_UNLOCK, ocrg_pkg::UNLOCK_KEY2);
      wr(8'h10, 32'hFFFF_FF20);
      rc(8'h10, 32'h20, "tune read");
      chk("tune port", 32'h20, {26'h0, tune});
      wr(8'h54, 32'h7);
      wr(8'h00, 32'h106);
      chk("usb sosc", 32'h3, {30'h0, usb, sosc});
      wr(8'h00, 32'h107);
      chk("busy", 32'h1, {31'h0, busy});
      repeat (30) @(negedge aclk);
      chk("switched", 32'h1, {28'h0, busy, cosc});
      chk("irq", 32'h1, {31'h0, irq});
      rc(8'h50, 32'h2, "switch status");
      chk("irq clear", 32'h0, {31'h0, irq});
      @(posedge aclk);
      fail <= 1'h1;
      @(posedge aclk);
      fail <= 1'h0;
      rc(8'h00, 32'h110E, "osc ctl");
      rc(8'h50, 32'h1, "fail status");
      wr(8'h30, 32'hFFFF_FFFF);
      rc(8'h30, 32'hFF80_0000, "trim");
      wr(8'h30, 32'h8000_0000);
      wr(8'h20, 32'h0001_1002);
      rc(8'h20, 32'h0001_1002, "ref ctl");
      wr(8'h20, 32'h0001_9002);
      per();
      per();
      chk("period 1.5", 32'h6, n);
      chk("request", 32'h1, {31'h0, act});
      wr(8'h30, 32'h0);
      per();
      chk("trim held", 32'h6, n);
      wr(8'h20, 32'h0001_9202);
      per();
      per();
      chk("period 1", 32'h4, n);
      rc(8'h20, 32'h0001_9102, "switch done");
      @(posedge aclk);
      idle <= 1'h1;
      per();
      chk("idle run", 32'h4, n);
      @(posedge aclk);
      slp <= 1'h1;
      per();
      chk("sleep stop", 32'd400, n);
      chk("sleep req", 32'h0, {31'h0, act});
      wr(8'h20, 32'h0001_9802);
      per();
      per();
      chk("sleep run", 32'h4, n);
      wr(8'h20, 32'h0001_1002);
      wr(8'h20, 32'h0001_9800);
      per();
      chk("sleep sys src", 32'd400, n);
      @(posedge aclk);
      slp <= 1'h0;
      wr(8'h20, 32'h0001_1002);
      wr(8'h20, 32'h0001_B002);
      per();
      chk("idle stop", 32'd400, n);
      @(posedge aclk);
      idle <= 1'h0;
      wr(8'h20, 32'h0001_8002);
      per();
      chk("no output", 32'd400, n);
      wr(8'h20, 32'h0001_0002);
      wr(8'h20, 32'h0001_9009);
      per();
      chk("reserved src", 32'd400, n);
      conclude();
   end
endmodule // osc_control_and_ref_clock_gen_tb
`default_nettype wire
